// ==== rtl/sps_consts.vh ====
// Purpose: constants for the serial port pin and line status block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses
`ifndef SPS_CONSTS_VH
`define SPS_CONSTS_VH
`define SPS_OFF_PIN_PORT    12'h000
`define SPS_OFF_LINE_STATUS 12'h004
`define SPS_OFF_SER_CTRL    12'h008
`define SPS_OFF_FIFO_CTRL   12'h00C
`define SPS_OFF_IRQ_STATUS  12'h010
`define SPS_OFF_IRQ_MASK    12'h014
`define SPS_OFF_PRIORITY    12'h018
`define SPS_OFF_EVENT_CODE  12'h01C
`define SPS_BIT_SPB_DATA    0
`define SPS_BIT_SPB_DIR     1
`define SPS_BIT_CTS_DATA    4
`define SPS_BIT_CTS_DIR     5
`define SPS_BIT_RTS_DATA    6
`define SPS_BIT_RTS_DIR     7
`define SPS_BIT_RE          4
`define SPS_BIT_TE          5
`define SPS_BIT_MCE         3
`define SPS_PIN_PORT_WMASK  8'hFF
`define SPS_EVT_ERI         12'h700
`define SPS_EVT_RXI         12'h720
`define SPS_EVT_BRI         12'h740
`define SPS_EVT_TXI         12'h760
`define SPS_EVT_NONE        12'h000
`define SPS_PRIO_RESET      4'h0
`endif

// ==== rtl/sps_port_status.v ====
// Purpose: pin port control, overrun status and interrupts of a fifo serial interface
// Assumes: single clock pclk at 10 MHz, apb slave, receive engine is outside
// Notes:   pins from outside pass two flip-flops before use
// Functional notes
// R1 - pin port register upper byte reads zero
// R2 - reset clears pin port except bits 6,4,0
// R3 - pin port kept in standby, always accessible
// R4 - bits 1,0 sample rx, drive tx, break
// R5 - bits 5,4 read and drive cts pin
// R6 - bits 6,7 read and drive rts pin
// R7 - rts direction bit gates rts data drive
// R8 - software clears modem enable before port rts
// R9 - overrun set when frame ends, fifo full
// R10 - overrun clears by write 0 after read 1
// R11 - receive disable leaves overrun unchanged
// R12 - overrun keeps fifo bytes, drops newer ones
// R13 - no reception while overrun flag set
// R14 - pins are mode inputs until enables set
// R15 - serial clock pin doubles as manual reset
// R16 - four events share priority, fixed internal order
// R17 - overrun raises receive error request until cleared
//
// Added by the designer: the register addresses and the APB slave port.
`include "sps_consts.vh"
module sps_port_status (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    input  wire        receive_pin,
    output wire        transmit_pin,
    output wire        transmit_pin_oe_n,
    input  wire        clear_to_send_pin_in,
    output wire        clear_to_send_pin_out,
    output wire        clear_to_send_pin_oe_n,
    input  wire        request_to_send_pin_in,
    output wire        request_to_send_pin_out,
    output wire        request_to_send_pin_oe_n,
    input  wire        serial_clock_in_pin,
    output wire        manual_reset_req,
    output reg  [2:0]  boot_mode_latched,
    input  wire        engine_tx_data,
    input  wire        engine_rts,
    input  wire        frame_done,
    input  wire        rx_fifo_full,
    output wire        rx_accept,
    output wire        rx_fifo_write,
    input  wire        rx_full_event,
    input  wire        break_event,
    input  wire        tx_empty_event,
    input  wire        manual_reset_active,
    output reg  [3:0]  irq_priority,
    output reg  [11:0] event_code,
    output wire        irq
);
    // synchronised pins
    reg  [1:0] rx_sync;
    reg  [1:0] cts_sync;
    reg  [1:0] rts_sync;
    reg  [1:0] sck_sync;
    reg  [7:0] pin_port;
    reg        overrun_flag;
    reg        overrun_seen;
    reg        receive_enable_bit;
    reg        transmit_enable_bit;
    reg        modem_ctrl_enable;
    reg  [3:0] irq_status;
    reg  [3:0] irq_mask;
    reg  [1:0] mode_wait;
    wire       wr_en;
    wire       rd_en;
    wire       rx_s;
    wire       cts_s;
    wire       rts_s;
    wire [3:0] pend;
    wire       overrun_set;
    wire [3:0] events;

    function is_addr;
        input [11:0] a;
        input [11:0] off;
        begin
            is_addr = (a[11:2] == off[11:2]);
        end
    endfunction

    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & penable & ~pwrite;
    assign rx_s    = rx_sync[1];
    assign cts_s   = cts_sync[1];
    assign rts_s   = rts_sync[1];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_sync  <= 2'b11;
            cts_sync <= 2'b11;
            rts_sync <= 2'b11;
            sck_sync <= 2'b11;
        end else begin
            rx_sync  <= {rx_sync[0], receive_pin};
            cts_sync <= {cts_sync[0], clear_to_send_pin_in};
            rts_sync <= {rts_sync[0], request_to_send_pin_in};
            sck_sync <= {sck_sync[0], serial_clock_in_pin};
        end
    end

    // sck pin is the manual reset input while a manual reset runs; active low
    assign manual_reset_req = manual_reset_active & ~sck_sync[1]; // R15

    // pins are mode straps after power-on; wait until the synchronisers
    // hold real pin levels, since their reset value is not a pin value
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_wait         <= 2'b00;
            boot_mode_latched <= 3'b000;
        end else if (mode_wait != 2'b11) begin
            mode_wait <= mode_wait + 2'b01;
            if (mode_wait == 2'b10) begin
                boot_mode_latched <= {rts_s, rx_s, 1'b0}; // R14
            end
        end
    end

    // serial function only after enables; until then the pins stay undriven
    assign transmit_pin = pin_port[`SPS_BIT_SPB_DIR] ? pin_port[`SPS_BIT_SPB_DATA]
                        : engine_tx_data; // R4
    assign transmit_pin_oe_n = ~(pin_port[`SPS_BIT_SPB_DIR] | transmit_enable_bit); // R14
    assign clear_to_send_pin_out  = pin_port[`SPS_BIT_CTS_DATA]; // R5
    assign clear_to_send_pin_oe_n = ~pin_port[`SPS_BIT_CTS_DIR]; // R5
    // port drive wins only if software cleared modem enable first
    assign request_to_send_pin_out = modem_ctrl_enable ? engine_rts
                                   : pin_port[`SPS_BIT_RTS_DATA]; // R8
    assign request_to_send_pin_oe_n = ~(pin_port[`SPS_BIT_RTS_DIR]
                                      | modem_ctrl_enable); // R7

    // pin port register, not touched by standby: only presetn clears it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_port <= 8'h00; // R2
        end else if (wr_en && is_addr(paddr, `SPS_OFF_PIN_PORT)) begin
            pin_port <= pwdata[7:0] & `SPS_PIN_PORT_WMASK; // R3
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            receive_enable_bit  <= 1'b0;
            transmit_enable_bit <= 1'b0;
            modem_ctrl_enable   <= 1'b0;
            irq_mask            <= 4'h0;
            irq_priority        <= `SPS_PRIO_RESET;
        end else if (wr_en) begin
            if (is_addr(paddr, `SPS_OFF_SER_CTRL)) begin
                receive_enable_bit  <= pwdata[`SPS_BIT_RE]; // R11
                transmit_enable_bit <= pwdata[`SPS_BIT_TE];
            end else if (is_addr(paddr, `SPS_OFF_FIFO_CTRL)) begin
                modem_ctrl_enable <= pwdata[`SPS_BIT_MCE];
            end else if (is_addr(paddr, `SPS_OFF_IRQ_MASK)) begin
                irq_mask <= pwdata[3:0];
            end else if (is_addr(paddr, `SPS_OFF_PRIORITY)) begin
                irq_priority <= pwdata[3:0]; // R16
            end
        end
    end

    // frame accepted only while enabled and no overrun pending
    assign rx_accept     = receive_enable_bit & ~overrun_flag; // R13
    assign overrun_set   = frame_done & rx_accept & rx_fifo_full; // R9
    assign rx_fifo_write = frame_done & rx_accept & ~rx_fifo_full; // R12

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overrun_flag <= 1'b0;
            overrun_seen <= 1'b0;
        end else begin
            if (rd_en && is_addr(paddr, `SPS_OFF_LINE_STATUS) && overrun_flag)
                overrun_seen <= 1'b1;
            if (overrun_set) begin
                overrun_flag <= 1'b1; // R9
            end else if (wr_en && is_addr(paddr, `SPS_OFF_LINE_STATUS)
                         && !pwdata[0] && overrun_seen) begin
                overrun_flag <= 1'b0; // R10
                overrun_seen <= 1'b0;
            end
        end
    end

    // sticky status cleared by reading it; a same-cycle event still sets
    assign events = {tx_empty_event, break_event, rx_full_event, overrun_set};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= 4'h0;
        end else if (rd_en && is_addr(paddr, `SPS_OFF_IRQ_STATUS)) begin
            irq_status <= events;
        end else begin
            irq_status <= irq_status | events;
        end
    end

    // receive error stays requested while overrun flag is up
    assign pend = {irq_status[3:1], irq_status[0] | overrun_flag} & irq_mask; // R17
    assign irq  = |pend;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_code <= `SPS_EVT_NONE;
        end else if (pend[0]) begin
            event_code <= `SPS_EVT_ERI; // R16
        end else if (pend[1]) begin
            event_code <= `SPS_EVT_RXI;
        end else if (pend[2]) begin
            event_code <= `SPS_EVT_BRI;
        end else if (pend[3]) begin
            event_code <= `SPS_EVT_TXI;
        end else begin
            event_code <= `SPS_EVT_NONE;
        end
    end

    always @* begin
        prdata = 32'h0000_0000;
        if (is_addr(paddr, `SPS_OFF_PIN_PORT)) begin
            // upper byte reads zero; data bits read the live pins
            prdata[7:0] = {pin_port[7], rts_s, pin_port[5], cts_s,
                           2'b00, pin_port[1], rx_s}; // R1 R4 R5 R6
        end else if (is_addr(paddr, `SPS_OFF_LINE_STATUS)) begin
            prdata[0] = overrun_flag;
        end else if (is_addr(paddr, `SPS_OFF_SER_CTRL)) begin
            prdata[`SPS_BIT_RE] = receive_enable_bit;
            prdata[`SPS_BIT_TE] = transmit_enable_bit;
        end else if (is_addr(paddr, `SPS_OFF_FIFO_CTRL)) begin
            prdata[`SPS_BIT_MCE] = modem_ctrl_enable;
        end else if (is_addr(paddr, `SPS_OFF_IRQ_STATUS)) begin
            prdata[3:0] = irq_status;
        end else if (is_addr(paddr, `SPS_OFF_IRQ_MASK)) begin
            prdata[3:0] = irq_mask;
        end else if (is_addr(paddr, `SPS_OFF_PRIORITY)) begin
            prdata[3:0] = irq_priority;
        end else if (is_addr(paddr, `SPS_OFF_EVENT_CODE)) begin
            prdata[11:0] = event_code;
        end
    end
endmodule // sps_port_status

// ==== dv/sps_port_status_monitor.sv ====
// Purpose: port assertions for the pin port and line status block
// Assumes: single pclk domain, async active-low reset
// Notes:   bound to the design top by name
module sps_port_status_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        transmit_pin,
    input wire logic        transmit_pin_oe_n,
    input wire logic        clear_to_send_pin_out,
    input wire logic        clear_to_send_pin_oe_n,
    input wire logic        request_to_send_pin_oe_n,
    input wire logic        serial_clock_in_pin,
    input wire logic        manual_reset_req,
    input wire logic        manual_reset_active,
    input wire logic        frame_done,
    input wire logic        rx_fifo_full,
    input wire logic        rx_accept,
    input wire logic        rx_fifo_write,
    input wire logic        irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_acc(a, w); psel && penable && pwrite == w && paddr == a; endsequence
    sequence s_port_wr; s_acc(12'h000, 1'b1); endsequence
    property p_upper_zero; s_acc(12'h000, 1'b0) |-> prdata[31:8] == 24'h0; endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("port upper byte set");
    property p_reset_idle;
        $rose(presetn) |-> transmit_pin_oe_n && clear_to_send_pin_oe_n
            && request_to_send_pin_oe_n && !irq;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("pins driven after reset");
    property p_tx_port; s_port_wr ##0 pwdata[1] |=> !transmit_pin_oe_n
        && transmit_pin == $past(pwdata[0]); endproperty
    a_tx_port: assert property (p_tx_port) else $error("tx port drive wrong");
    property p_cts; s_port_wr |=> clear_to_send_pin_oe_n == !$past(pwdata[5])
        && clear_to_send_pin_out == $past(pwdata[4]); endproperty
    a_cts: assert property (p_cts) else $error("cts port drive wrong");
    property p_rts_dir; s_port_wr ##0 pwdata[7] |=> !request_to_send_pin_oe_n; endproperty
    a_rts_dir: assert property (p_rts_dir) else $error("rts not driven");
    property p_overrun; frame_done && rx_fifo_full && rx_accept |=> !rx_accept [*2]; endproperty
    a_overrun: assert property (p_overrun) else $error("reception went on");
    property p_keep_fifo;
        rx_fifo_write |-> frame_done && !rx_fifo_full && rx_accept;
    endproperty
    a_keep_fifo: assert property (p_keep_fifo) else $error("bad fifo write");
    property p_w1; s_acc(12'h004, 1'b1) ##0 pwdata[0] ##0 !rx_accept |=> !rx_accept; endproperty
    a_w1: assert property (p_w1) else $error("write one cleared overrun");
    property p_manual_reset_input;
        (manual_reset_active && !serial_clock_in_pin) [*4] |-> manual_reset_req;
    endproperty
    a_manual_reset_input: assert property (p_manual_reset_input) else $error("manual reset missed");
endmodule // sps_port_status_monitor
bind sps_port_status sps_port_status_monitor u_sps_port_status_monitor (.*);

// ==== dv/sps_remote_dev.sv ====
// Purpose: far-side pins of a remote modem device
// Assumes: far side drives its lines unless the block drives them
// Notes:   levels come from the bench
module sps_remote_dev (
    input  wire logic [2:0] lvl,
    input  wire logic       clear_to_send_pin_out,
    input  wire logic       clear_to_send_pin_oe_n,
    input  wire logic       request_to_send_pin_out,
    input  wire logic       request_to_send_pin_oe_n,
    output wire logic       receive_pin,
    output wire logic       clear_to_send_pin_in,
    output wire logic       request_to_send_pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    assign receive_pin = lvl[0];
    // the block wins the wire while its enable is low
    assign clear_to_send_pin_in = clear_to_send_pin_oe_n ? lvl[1] : clear_to_send_pin_out;
    assign request_to_send_pin_in = request_to_send_pin_oe_n ? lvl[2] : request_to_send_pin_out;
endmodule // sps_remote_dev

// ==== dv/sps_port_status_tb.sv ====
// Purpose: self-checking bench of the pin port and line status block
// Assumes: apb master, far side model on the pins
// Notes:   mask bit 1 enables an interrupt
module sps_port_status_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, receive_pin, transmit_pin;
    logic [11:0] paddr, event_code;
    logic [31:0] pwdata, prdata, rd;
    logic transmit_pin_oe_n, clear_to_send_pin_in, clear_to_send_pin_out, clear_to_send_pin_oe_n;
    logic request_to_send_pin_in, request_to_send_pin_out, request_to_send_pin_oe_n;
    logic serial_clock_in_pin, manual_reset_req, engine_tx_data, engine_rts, frame_done;
    logic rx_fifo_full, rx_accept, rx_fifo_write, rx_full_event, break_event, tx_empty_event;
    logic manual_reset_active, irq;
    logic [2:0] boot_mode_latched, lvl;
    logic [3:0] irq_priority;
    int err_total, samples_checked, cyc;
    logic [7:0] wv [4] = '{8'h00, 8'hF2, 8'hA3, 8'h50};
    logic [2:0] lv [4] = '{3'b011, 3'b000, 3'b111, 3'b100};
    logic [7:0] ev [4] = '{8'h11, 8'hF2, 8'hA3, 8'h40};
    logic [11:0] ec [3] = '{12'h760, 12'h740, 12'h720};
    sps_port_status u_sps_port_status (.*);
    sps_remote_dev u_sps_remote_dev (.*);
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic frame(input logic f);
        rx_fifo_full <= f;
        frame_done <= 1'b1;
        @(posedge pclk);
        rd = {31'h0, rx_fifo_write};
        frame_done <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc > 3000) begin
            err_total++;
            tally_and_finish();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, engine_tx_data, engine_rts} = '0;
        {frame_done, rx_fifo_full, rx_full_event, break_event, tx_empty_event} = '0;
        {manual_reset_active, serial_clock_in_pin, lvl} = {2'b01, 3'b010};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd & 32'hFFFF_FFAE, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0);
        chk(boot_mode_latched, 32'h0);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            lvl <= lv[i];
            apb(1'b1, 12'h000, {24'h0, wv[i]});
            repeat (3) @(posedge pclk);
            apb(1'b0, 12'h000, 32'h0);
            chk(rd, {24'h0, ev[i]});
            chk(transmit_pin_oe_n, !wv[i][1]);
            $display("row %0d done", i);
        end
        engine_rts <= 1'b1;
        apb(1'b1, 12'h00C, 32'h8);
        chk({request_to_send_pin_oe_n, request_to_send_pin_out}, 2'b01);
        apb(1'b1, 12'h00C, 32'h0);
        apb(1'b1, 12'h008, 32'h10);
        frame(1'b0);
        chk(rd, 32'h1);
        frame(1'b1);
        chk(rd, 32'h0);
        frame(1'b0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h008, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, 12'h014, 32'hF);
        apb(1'b1, 12'h018, 32'h5);
        chk(irq_priority, 32'h5);
        chk(irq, 32'h1);
        apb(1'b0, 12'h01C, 32'h0);
        chk(rd, 32'h700);
        apb(1'b1, 12'h004, 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h008, 32'h10);
        chk(rx_accept, 32'h1);
        apb(1'b0, 12'h010, 32'h0);
        $display("overrun test done");
        for (int i = 0; i < 3; i++) begin
            {rx_full_event, break_event, tx_empty_event} <= 3'b001 << i;
            @(posedge pclk);
            {rx_full_event, break_event, tx_empty_event} <= 3'b000;
            repeat (2) @(posedge pclk);
            chk(event_code, ec[i]);
        end
        apb(1'b1, 12'h014, 32'h0);
        chk(irq, 32'h0);
        apb(1'b1, 12'h014, 32'hF);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'hE);
        chk(irq, 32'h0);
        serial_clock_in_pin <= 1'b0;
        manual_reset_active <= 1'b1;
        repeat (5) @(posedge pclk);
        chk(manual_reset_req, 32'h1);
        $display("irq and reset pin test done");
        tally_and_finish();
    end
endmodule // sps_port_status_tb
